// ===== design/hrdop_top.sv
`default_nettype none
`include "hrdop_map.svh"
module hrdop_top
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire hrdop_pkg::hrdop_duty_t loop_filter_duty,
    input  wire logic                   loop_filter_valid,
    input  wire logic                   sync_in,
    output logic                        sync_out,
    output logic                        pwm_a,
    output logic                        pwm_b,
    output logic [3:0]                  fine_a_fall,
    output logic [3:0]                  fine_b_rise,
    output logic [3:0]                  fine_b_fall,
    output logic                        phase_clock_set_enable,
    output logic                        error_converter_trigger,
    output logic                        sample2_trigger,
    output logic                        blank_a,
    output logic                        blank_b,
    output logic                        period_irq,
    output logic                        twelve_bit_converter_start
);
    import hrdop_pkg::*;

    // Registers
    logic [`HRDOP_CTRL_W-1:0] ctrl_q;
    hrdop_cnt_t               prd_sh_q;
    hrdop_cnt_t               prd_act_q;
    hrdop_cnt_t               ev1_q;
    hrdop_pos_t               ev2_q;
    hrdop_pos_t               ev3_q;
    hrdop_pos_t               ev4_q;
    hrdop_adj_t               adja_q;
    hrdop_adj_t               adjb_q;
    logic [`HRDOP_SMP_W-1:0]  smp1_q;
    logic [`HRDOP_SMP_W-1:0]  smp2_q;
    hrdop_cnt_t               phase_q;
    logic [31:0]              blka_q;
    logic [31:0]              blkb_q;

    // Datapath state
    hrdop_cnt_t  cnt_q;
    logic [14:0] seg_cnt_q;
    logic [22:0] duty_q;
    logic [22:0] duty_act_q;
    hrdop_pos_t  on_q;
    logic [7:0]  div_cnt_q;
    logic        a_q;
    logic        b_q;
    logic        sync1_q;
    logic        sync2_q;
    logic        sync3_q;
    logic        trig_q;
    logic        trig2_q;
    logic        sync_out_q;
    logic        irq_q;
    logic        blank_a_q;
    logic        blank_b_q;
    logic        pwm_a_q;
    logic        pwm_b_q;
    logic [31:0] prdata_q;

    // Decoded controls and combinational terms
    logic        en_q;
    logic        closed;
    hrdop_os_t   os;
    logic        fine_on;
    logic [3:0]  mask;
    logic        term;
    logic        sync_pulse;
    logic        wr;
    logic        map_ok;
    logic [31:0] rd_mux;
    logic        prd_wr;
    hrdop_pos_t  a_fall_base;
    hrdop_pos_t  b_fall_base;
    logic        a_rise_hit;
    logic        a_fall_hit;
    logic        b_rise_hit;
    logic        b_fall_hit;
    logic [14:0] seg_len;
    hrdop_cnt_t  smp1_fast;
    hrdop_cnt_t  smp2_fast;
    logic [7:0]  div_lim;
    logic        div_on;
    logic [41:0] prod;
    logic        a_d;
    logic        b_d;

    // Saturate a 19-bit sum into a fine position
    function automatic hrdop_pos_t sat19(input logic [18:0] v);
        sat19 = v[18] ? 18'h3ffff : v[17:0];
    endfunction : sat19

    // Interrupt divide setting to divide count
    function automatic logic [7:0] div_map(input logic [3:0] s);
        unique case (s)
            4'h1:    div_map = 8'h00;
            4'h2:    div_map = 8'h01;
            4'h3:    div_map = 8'h03;
            4'h4:    div_map = 8'h07;
            4'h5:    div_map = 8'h0f;
            4'h6:    div_map = 8'h1f;
            4'h7:    div_map = 8'h2f;
            4'h8:    div_map = 8'h3f;
            4'h9:    div_map = 8'h4f;
            4'ha:    div_map = 8'h5f;
            4'hb:    div_map = 8'h7f;
            4'hc:    div_map = 8'h9f;
            4'hd:    div_map = 8'hbf;
            4'he:    div_map = 8'hdf;
            4'hf:    div_map = 8'hff;
            default: div_map = 8'h00;
        endcase
    endfunction : div_map

    // Control field decode
    assign en_q    = ctrl_q[`HRDOP_C_EN];
    assign closed  = ctrl_q[`HRDOP_C_CLOSED];
    assign os      = hrdop_os_t'(ctrl_q[`HRDOP_C_OS]);
    assign fine_on = ctrl_q[`HRDOP_C_FINE] & ctrl_q[`HRDOP_C_PHCLK];
    assign div_lim = div_map(ctrl_q[`HRDOP_C_DIV]);
    assign div_on  = (ctrl_q[`HRDOP_C_DIV] != 4'h0);

    // Step size to sub-step mask; off means whole 4 ns steps
    always_comb
    begin
        mask = 4'h0;
        if (fine_on)
        begin
            unique case (hrdop_step_t'(ctrl_q[`HRDOP_C_STEP]))
                HRDOP_ST250P: mask = 4'hf;
                HRDOP_ST500P: mask = 4'he;
                HRDOP_ST1N:   mask = 4'hc;
                HRDOP_ST2N:   mask = 4'h8;
            endcase
        end
    end

    // APB access decode, zero wait states
    assign wr      = psel & penable & pwrite;
    assign prd_wr  = wr & (paddr == ADDR_W'(`HRDOP_PRD_OFS));
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~map_ok;

    // Register read mux and address check
    always_comb
    begin
        map_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_W'(`HRDOP_CTRL_OFS): rd_mux = 32'(ctrl_q);
            ADDR_W'(`HRDOP_PRD_OFS):  rd_mux = 32'(prd_sh_q);
            ADDR_W'(`HRDOP_EV1_OFS):  rd_mux = 32'(ev1_q);
            ADDR_W'(`HRDOP_EV2_OFS):  rd_mux = 32'(ev2_q);
            ADDR_W'(`HRDOP_EV3_OFS):  rd_mux = 32'(ev3_q);
            ADDR_W'(`HRDOP_EV4_OFS):  rd_mux = 32'(ev4_q);
            ADDR_W'(`HRDOP_ADJA_OFS): rd_mux = 32'($unsigned(adja_q));
            ADDR_W'(`HRDOP_ADJB_OFS): rd_mux = 32'($unsigned(adjb_q));
            ADDR_W'(`HRDOP_SMP1_OFS): rd_mux = 32'(smp1_q);
            ADDR_W'(`HRDOP_SMP2_OFS): rd_mux = 32'(smp2_q);
            ADDR_W'(`HRDOP_PHS_OFS):  rd_mux = 32'(phase_q);
            ADDR_W'(`HRDOP_BLKA_OFS): rd_mux = blka_q;
            ADDR_W'(`HRDOP_BLKB_OFS): rd_mux = blkb_q;
            ADDR_W'(`HRDOP_STAT_OFS):
                rd_mux = {div_cnt_q, 6'h00, b_q, a_q, 2'b00, cnt_q};
            default:                  map_ok = 1'b0;
        endcase
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata_q <= rd_mux;
    end
    assign prdata = prdata_q;

    // Register writes; period goes to its shadow copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= `HRDOP_CTRL_RST;
            prd_sh_q <= `HRDOP_PRD_RST;
            ev1_q    <= '0;
            ev2_q    <= '0;
            ev3_q    <= '0;
            ev4_q    <= '0;
            adja_q   <= '0;
            adjb_q   <= '0;
            smp1_q   <= '0;
            smp2_q   <= '0;
            phase_q  <= '0;
            blka_q   <= 32'h0000_0000;
            blkb_q   <= 32'h0000_0000;
        end
        else if (wr)
        begin
            unique case (paddr)
                ADDR_W'(`HRDOP_CTRL_OFS): ctrl_q <= pwdata[`HRDOP_CTRL_W-1:0];
                ADDR_W'(`HRDOP_PRD_OFS):  prd_sh_q <= pwdata[13:0];
                ADDR_W'(`HRDOP_EV1_OFS):  ev1_q <= pwdata[13:0];
                ADDR_W'(`HRDOP_EV2_OFS):  ev2_q <= pwdata[17:0];
                ADDR_W'(`HRDOP_EV3_OFS):  ev3_q <= pwdata[17:0];
                ADDR_W'(`HRDOP_EV4_OFS):  ev4_q <= pwdata[17:0];
                ADDR_W'(`HRDOP_ADJA_OFS): adja_q <= pwdata[15:0];
                ADDR_W'(`HRDOP_ADJB_OFS): adjb_q <= pwdata[15:0];
                ADDR_W'(`HRDOP_SMP1_OFS): smp1_q <= pwdata[`HRDOP_SMP_W-1:0];
                ADDR_W'(`HRDOP_SMP2_OFS): smp2_q <= pwdata[`HRDOP_SMP_W-1:0];
                ADDR_W'(`HRDOP_PHS_OFS):  phase_q <= pwdata[13:0];
                ADDR_W'(`HRDOP_BLKA_OFS): blka_q <= pwdata;
                ADDR_W'(`HRDOP_BLKB_OFS): blkb_q <= pwdata;
                default:                  ;
            endcase
        end
    end

    // Alignment input synchroniser and rising-edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign sync_pulse = sync2_q & ~sync3_q;

    // Period counter, restarted by period end or alignment
    assign term = (cnt_q == prd_act_q);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (!en_q || sync_pulse)
            cnt_q <= '0;
        else if (term)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 14'h0001;
    end

    // Active period and duty taken at period end and while disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prd_act_q  <= `HRDOP_PRD_RST;
            duty_act_q <= '0;
        end
        else if (!en_q || term)
        begin
            prd_act_q  <= prd_sh_q;
            duty_act_q <= duty_q;
        end
    end

    // Compensator duty, negative values clamp to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            duty_q <= '0;
        else if (loop_filter_valid)
            duty_q <= loop_filter_duty[23] ? 23'h000000 : loop_filter_duty[22:0];
    end

    // On-time in sub-steps: duty times period in sixteenths
    assign prod = duty_act_q * {({1'b0, prd_act_q} + 15'h0001), 4'h0};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            on_q <= '0;
        else
            on_q <= sat19(prod[41:23]);
    end

    // Falling-edge bases; open loop ignores the compensator
    assign a_fall_base = closed ? sat19({1'b0, ev1_q, 4'h0} + {1'b0, on_q})
                                : ev2_q;
    assign b_fall_base = closed ? sat19({1'b0, ev3_q} + {1'b0, on_q})
                                : ev4_q;

    // Edge comparators with fine sub-step capture, left unconnected on the A rising edge
    hrdop_edge u_a_rise (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (cnt_q),
        .base    ({ev1_q, 4'h0}),
        .adj     (16'sh0000),
        .mask    (mask),
        .hit     (a_rise_hit),
        .fine    ()
    );
    hrdop_edge u_a_fall (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (cnt_q),
        .base    (a_fall_base),
        .adj     (adja_q),
        .mask    (mask),
        .hit     (a_fall_hit),
        .fine    (fine_a_fall)
    );
    hrdop_edge u_b_rise (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (cnt_q),
        .base    (ev3_q),
        .adj     (16'sh0000),
        .mask    (mask),
        .hit     (b_rise_hit),
        .fine    (fine_b_rise)
    );
    hrdop_edge u_b_fall (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (cnt_q),
        .base    (b_fall_base),
        .adj     (adjb_q),
        .mask    (mask),
        .hit     (b_fall_hit),
        .fine    (fine_b_fall)
    );

    // Output set/clear; a falling match wins over a rising one
    assign a_d = !en_q ? 1'b0 : a_fall_hit ? 1'b0 : a_rise_hit ? 1'b1 : a_q;
    assign b_d = !en_q ? 1'b0 : b_fall_hit ? 1'b0 : b_rise_hit ? 1'b1 : b_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
        end
        else
        begin
            a_q     <= a_d;
            b_q     <= b_d;
            pwm_a_q <= a_d ^ ctrl_q[`HRDOP_C_POLA];
            pwm_b_q <= b_d ^ ctrl_q[`HRDOP_C_POLB];
        end
    end
    assign pwm_a = pwm_a_q;
    assign pwm_b = pwm_b_q;
    assign phase_clock_set_enable = ctrl_q[`HRDOP_C_PHCLK];

    // Sample points scaled from quarter-rate units
    assign smp1_fast = {smp1_q, 2'b00};
    assign smp2_fast = {smp2_q, 2'b00};
    assign seg_len   = ({1'b0, prd_act_q} + 15'h0001) >> os;

    // Oversampling segment counter, aligned with the period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seg_cnt_q <= '0;
        else if (!en_q || sync_pulse || term || seg_cnt_q >= seg_len - 15'h0001)
            seg_cnt_q <= '0;
        else
            seg_cnt_q <= seg_cnt_q + 15'h0001;
    end

    // Trigger, alignment and blanking pulses from own settings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_q     <= 1'b0;
            trig2_q    <= 1'b0;
            sync_out_q <= 1'b0;
            blank_a_q  <= 1'b0;
            blank_b_q  <= 1'b0;
        end
        else
        begin
            trig_q     <= en_q && (seg_cnt_q == ({1'b0, smp1_fast} >> os));
            trig2_q    <= en_q && (cnt_q == smp2_fast);
            sync_out_q <= en_q && (cnt_q == phase_q);
            blank_a_q  <= en_q && cnt_q >= blka_q[`HRDOP_BLK_BEG]
                          && cnt_q < blka_q[`HRDOP_BLK_END];
            blank_b_q  <= en_q && cnt_q >= blkb_q[`HRDOP_BLK_BEG]
                          && cnt_q < blkb_q[`HRDOP_BLK_END];
        end
    end
    assign error_converter_trigger = trig_q;
    assign sample2_trigger         = trig2_q;
    assign sync_out                = sync_out_q;
    assign blank_a                 = blank_a_q;
    assign blank_b                 = blank_b_q;

    // Divided per-period interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_q <= 8'h00;
            irq_q     <= 1'b0;
        end
        else
        begin
            irq_q <= 1'b0;
            if (!en_q || !div_on)
                div_cnt_q <= 8'h00;
            else if (term && !sync_pulse)
            begin
                if (div_cnt_q >= div_lim)
                begin
                    div_cnt_q <= 8'h00;
                    irq_q     <= 1'b1;
                end
                else
                    div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end
    assign period_irq                 = irq_q;
    assign twelve_bit_converter_start = irq_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence period_end_s;
        en_q && term && !sync_pulse;
    endsequence
    sequence sync_seen_s;
        en_q && sync_pulse;
    endsequence

    cnt_wrap_a: assert property (period_end_s |=> cnt_q == 14'h0000)
        else $error("counter did not wrap at period end");
    cnt_bound_a: assert property (en_q |-> cnt_q <= prd_act_q)
        else $error("counter beyond period");
    sync_clear_a: assert property (sync_seen_s |=> cnt_q == 14'h0000)
        else $error("alignment pulse did not clear counter");
    shadow_hold_a: assert property (en_q && prd_wr && !term |=> $stable(prd_act_q))
        else $error("period changed before period end");
    shadow_take_a: assert property (period_end_s |=> prd_act_q == $past(prd_sh_q))
        else $error("shadow period not taken");
    sync_out_a: assert property (en_q && cnt_q == phase_q |=> sync_out)
        else $error("alignment output missing");
    sample_trig_a: assert property (en_q && os == HRDOP_OS1
        && seg_cnt_q == 15'(cnt_q) && cnt_q == smp1_fast |=> error_converter_trigger)
        else $error("sample trigger missing");
    open_loop_a: assert property (en_q && !closed && a_fall_hit
        |=> pwm_a == $past(ctrl_q[`HRDOP_C_POLA]))
        else $error("open loop output A did not fall");
    irq_div_a: assert property (period_end_s and (div_on && div_cnt_q == div_lim)
        |=> period_irq && div_cnt_q == 8'h00)
        else $error("divided interrupt missing");
    a_rise_a: assert property (en_q && a_rise_hit && !a_fall_hit
        |=> pwm_a != $past(ctrl_q[`HRDOP_C_POLA]))
        else $error("output A did not assert");
endmodule : hrdop_top
`default_nettype wire

// ===== shared/hrdop_map.svh
`ifndef HRDOP_MAP_SVH
`define HRDOP_MAP_SVH

// Register byte offsets
`define HRDOP_CTRL_OFS 8'h00
`define HRDOP_PRD_OFS  8'h04
`define HRDOP_EV1_OFS  8'h08
`define HRDOP_EV2_OFS  8'h0c
`define HRDOP_EV3_OFS  8'h10
`define HRDOP_EV4_OFS  8'h14
`define HRDOP_ADJA_OFS 8'h18
`define HRDOP_ADJB_OFS 8'h1c
`define HRDOP_SMP1_OFS 8'h20
`define HRDOP_SMP2_OFS 8'h24
`define HRDOP_PHS_OFS  8'h28
`define HRDOP_BLKA_OFS 8'h2c
`define HRDOP_BLKB_OFS 8'h30
`define HRDOP_STAT_OFS 8'h34

// Control register fields
`define HRDOP_C_EN      0
`define HRDOP_C_CLOSED  1
`define HRDOP_C_POLA    2
`define HRDOP_C_POLB    3
`define HRDOP_C_OS      5:4
`define HRDOP_C_DIV     9:6
`define HRDOP_C_FINE    10
`define HRDOP_C_STEP    12:11
`define HRDOP_C_PHCLK   13
`define HRDOP_CTRL_W    14

// Other field layouts
`define HRDOP_BLK_BEG   13:0
`define HRDOP_BLK_END   29:16
`define HRDOP_SMP_W     12

// Reset values
`define HRDOP_CTRL_RST  14'h0000
`define HRDOP_PRD_RST   14'h3fff

// Fine placement and sample point scaling constants
`define HRDOP_STEP_PS   250
`define HRDOP_QR_SHIFT  2

`endif

// ===== shared/hrdop_pkg.sv
`default_nettype none
package hrdop_pkg;
    typedef logic [13:0]        hrdop_cnt_t;
    typedef logic [17:0]        hrdop_pos_t;
    typedef logic signed [15:0] hrdop_adj_t;
    typedef logic signed [23:0] hrdop_duty_t;
    typedef enum logic [1:0] {HRDOP_OS1, HRDOP_OS2, HRDOP_OS4, HRDOP_OS8} hrdop_os_t;
    typedef enum logic [1:0] {HRDOP_ST250P, HRDOP_ST500P, HRDOP_ST1N, HRDOP_ST2N} hrdop_step_t;
endpackage : hrdop_pkg
`default_nettype wire

// ===== design/hrdop_edge.sv
`default_nettype none
module hrdop_edge
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire hrdop_pkg::hrdop_cnt_t cnt,
    input  wire hrdop_pkg::hrdop_pos_t base,
    input  wire hrdop_pkg::hrdop_adj_t adj,
    input  wire logic [3:0]            mask,
    output logic                       hit,
    output logic [3:0]                 fine
);
    import hrdop_pkg::*;

    logic signed [19:0] sum;
    hrdop_pos_t         pos;

    // Signed adjust added onto count and sub-step bits
    assign sum = $signed({2'b00, base}) + 20'(adj);

    // Clamp into the counter range
    always_comb
    begin
        if (sum < 0)
            pos = '0;
        else if (sum > $signed({2'b00, 18'h3ffff}))
            pos = 18'h3ffff;
        else
            pos = sum[17:0];
    end

    // Coarse match on the upper 14 bits
    assign hit = (cnt == pos[17:4]);

    // Sub-step for the phase clock selector, held until the next hit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fine <= 4'h0;
        else if (hit)
            fine <= pos[3:0] & mask;
    end
endmodule : hrdop_edge
`default_nettype wire

// ===== test/hrdop_gate_model.sv
`default_nettype none
// Gate driver pair: reports the last on-time of each switch in pclk cycles
module hrdop_gate_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pwm_a,
    input  wire logic       pwm_b,
    output logic [7:0]      a_width,
    output logic [7:0]      b_width
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] a_run;
    logic [7:0] b_run;
    // Count high cycles, latch the count when the gate turns off
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_run = 8'h00;
            b_run = 8'h00;
            a_width = 8'h00;
            b_width = 8'h00;
        end
        else
        begin
            if (pwm_a) a_run = a_run + 8'h01;
            else if (a_run != 8'h00) begin a_width = a_run; a_run = 8'h00; end
            if (pwm_b) b_run = b_run + 8'h01;
            else if (b_run != 8'h00) begin b_width = b_run; b_run = 8'h00; end
        end
    end
endmodule : hrdop_gate_model
`default_nettype wire

// ===== test/high_res_dual_output_pwm_test.sv
`default_nettype none
`include "hrdop_map.svh"
module high_res_dual_output_pwm_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, sync_out, pwm_a, pwm_b, ect, irq, cst, e, s2, bla, blb, pce;
    logic        dv = 1'b0, sin = 1'b0;
    logic [23:0] duty = 24'h000000;
    logic [3:0]  fa, fbr, fbf;
    logic [7:0]  wa, wb;
    int          n_mismatch = 0, n_checks = 0, cyc = 0, ns, ni, nc, ne, n2, na, nb;
    // Clock and run limit
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 3000) begin n_mismatch++; end_of_test(); end
    hrdop_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_filter_duty(duty), .loop_filter_valid(dv),
        .sync_in(sin), .sync_out(sync_out), .pwm_a(pwm_a), .pwm_b(pwm_b), .fine_a_fall(fa),
        .fine_b_rise(fbr), .fine_b_fall(fbf), .phase_clock_set_enable(pce),
        .error_converter_trigger(ect), .sample2_trigger(s2), .blank_a(bla), .blank_b(blb),
        .period_irq(irq), .twelve_bit_converter_start(cst));
    hrdop_gate_model GATES (.pclk(pclk), .presetn(presetn), .pwm_a(pwm_a), .pwm_b(pwm_b),
        .a_width(wa), .b_width(wb));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Let start-up transients pass, then count the high cycles of the trigger, alignment, interrupt and blanking outputs over n cycles
    task win(input int n);
        repeat (8) @(posedge pclk);
        ns = 0; ni = 0; nc = 0; ne = 0; n2 = 0; na = 0; nb = 0;
        repeat (n)
        begin
            @(posedge pclk);
            ns += int'(sync_out === 1'b1);
            ni += int'(irq === 1'b1);
            nc += int'(cst === 1'b1);
            ne += int'(ect === 1'b1);
            n2 += int'(s2 === 1'b1);
            na += int'(bla === 1'b1);
            nb += int'(blb === 1'b1);
        end
    endtask : win
    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Half duty from the compensator, ignored while open loop
        duty <= 24'h400000;
        dv <= 1'b1;
        @(posedge pclk);
        dv <= 1'b0;
        apb(0, `HRDOP_PRD_OFS, 0);
        chk("prd reset", q, 32'h3fff);
        apb(0, 8'h38, 0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        // Inverted polarity while disabled gives idle-high outputs
        apb(1, `HRDOP_CTRL_OFS, 32'hc);
        repeat (2) @(posedge pclk);
        chk("idle pol", {30'h0, pwm_a, pwm_b}, 32'h3);
        apb(1, `HRDOP_PRD_OFS, 32'h3);
        apb(1, `HRDOP_EV1_OFS, 32'h1);
        apb(1, `HRDOP_EV2_OFS, 32'h30);
        apb(1, `HRDOP_EV3_OFS, 32'h10);
        apb(1, `HRDOP_EV4_OFS, 32'h20);
        apb(1, `HRDOP_ADJB_OFS, 32'h10);
        apb(1, `HRDOP_PHS_OFS, 32'h2);
        apb(1, `HRDOP_SMP1_OFS, 32'h0);
        // Period 4, interrupt every second period, oversampling codes 1x, 2x and 4x
        for (int os = 0; os < 3; os++)
        begin
            apb(1, `HRDOP_CTRL_OFS, 32'h81 | (os << 4));
            win(40);
            chk("sync", ns, 10);
            chk("irq", ni, 5);
            chk("adc start", nc, 5);
            chk("sample", ne, 10 << os);
        end
        chk("a width", wa, 2);
        chk("b width", wb, 2);
        apb(1, `HRDOP_PRD_OFS, 32'h7);
        repeat (8) @(posedge pclk);
        win(40);
        chk("sync prd7", ns, 5);
        // Closed loop at period 8, 250 ps fine placement, 8x sampling
        apb(1, `HRDOP_EV3_OFS, 32'h13);
        apb(1, `HRDOP_ADJA_OFS, 32'h5);
        apb(1, `HRDOP_BLKA_OFS, 32'h50002);
        apb(1, `HRDOP_BLKB_OFS, 32'h70006);
        apb(1, `HRDOP_SMP2_OFS, 32'h1);
        apb(1, `HRDOP_CTRL_OFS, 32'h2433);
        win(40);
        chk("closed a width", wa, 4);
        chk("closed b width", wb, 5);
        chk("fine codes", {fa, fbr, fbf}, 12'h533);
        chk("phase clk en", pce, 1);
        chk("sample 8x", ne, 40);
        chk("sample2", n2, 5);
        chk("blank a", na, 15);
        chk("blank b", nb, 5);
        chk("irq off", ni + nc, 0);
        // Alignment pin restarts the counter, seen in the status word
        sin <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, `HRDOP_STAT_OFS, 0);
        chk("sync in count", q[13:0], 14'h0000);
        sin <= 1'b0;
        end_of_test();
    end
endmodule : high_res_dual_output_pwm_test
`default_nettype wire
